//--- common/tcd_pkg.sv
package tcd_pkg;
   // field codes of the four-bit function select
   localparam logic [3:0] FSEL_RESET = 4'h0;
   localparam int FSEL_TOP = 3;
   localparam int FSEL_INIT = 2;
   localparam int FSEL_BOTH = 1;
   localparam int FSEL_FALL = 0;
   localparam logic [1:0] OC_OFF = 2'h0;
   localparam logic [1:0] OC_LOW = 2'h1;
   localparam logic [1:0] OC_HIGH = 2'h2;
   localparam logic [1:0] OC_TOGGLE = 2'h3;
   localparam logic [1:0] IC_PIN = 2'h2;
   localparam logic [1:0] IC_CASCADE = 2'h3;
   localparam logic [2:0] PSC_UNDIVIDED = 3'h0;
   localparam int CNT_W = 16;
   localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
   // register offsets, one word each
   localparam logic [3:0] ADDR_FUNC = 4'h0;
   localparam logic [3:0] ADDR_COMPARE = 4'h1;
   localparam logic [3:0] ADDR_CAPTURE = 4'h2;
   localparam logic [3:0] ADDR_STATUS = 4'h3;
   localparam logic [3:0] ADDR_CLEAR = 4'h4;
   localparam logic [3:0] ADDR_ENABLE = 4'h5;
   localparam logic [3:0] ADDR_MODE = 4'h6;
   // status bits
   localparam int ST_W = 2;
   localparam int ST_MATCH = 0;
   localparam int ST_CAPT = 1;
   localparam int MODE_BUF = 0;
   localparam int MODE_PSC = 1;
   localparam int MODE_PSC_W = 3;
   typedef enum logic [1:0] {TCD_OFF, TCD_COMPARE, TCD_CAPTURE} tcd_func_t;
endpackage

//--- design/tcd_ctrl.sv
`timescale 1ns/1ps
// Summary of operation
// - In compare mode with low bits 01 the pin is driven low on each counter match.
// - In compare mode with low bits 10 the pin is driven high on each counter match.
// - In compare mode with low bits 11 the pin level is inverted on each counter match.
// - Code 1000 captures the counter on a rising edge of the input pin.
// - Code 1001 captures the counter on a falling edge of the input pin.
// - Codes 101x capture the counter on both edges of the input pin.
// - Codes 11xx capture the counter whenever channel 4 counts up or down.
// - With channel 4 prescaler select 000 the cascade capture is suppressed.
// - With buffer mode set neither capture nor compare output happens.
module tcd_ctrl (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // register port
   input wire logic [3:0] addr,
   input wire logic [tcd_pkg::CNT_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [tcd_pkg::CNT_W-1:0] rdata,
   // counters and pin
   input wire logic [tcd_pkg::CNT_W-1:0] chan3_counter,
   input wire logic chan4_count_tick,
   input wire logic pin_in,
   output logic pin_out,
   output logic pin_oe,
   // interrupt
   output logic irq
);
   import tcd_pkg::*;

   logic [3:0] func_sel;
   logic [CNT_W-1:0] chan3_general_reg_d;
   logic [CNT_W-1:0] capture_val;
   logic reg_d_buffer_mode;
   logic [MODE_PSC_W-1:0] chan4_prescale_sel;
   logic [ST_W-1:0] status;
   logic [ST_W-1:0] enable;
   logic pin_level;
   logic pin_drive;
   logic [3:0] prev_func;
   logic [CNT_W-1:0] next_rdata;
   logic [3:0] next_func_sel;
   logic [CNT_W-1:0] next_reg_d;
   logic [CNT_W-1:0] next_capture_val;
   logic next_buffer_mode;
   logic [MODE_PSC_W-1:0] next_prescale;
   logic [ST_W-1:0] next_status;
   logic [ST_W-1:0] next_enable;
   logic next_pin_level;
   logic next_pin_drive;
   logic next_irq;
   logic rise;
   logic fall;
   logic match;
   logic capture;
   tcd_func_t func;

   function automatic tcd_func_t decode_func(input logic [3:0] sel);
      if (sel[FSEL_TOP]) begin
         decode_func = TCD_CAPTURE;
      end else if (sel[1:0] == OC_OFF) begin
         decode_func = TCD_OFF;
      end else begin
         decode_func = TCD_COMPARE;
      end
   endfunction

   tcd_edge_det u_edge (
      .clk(clk),
      .rstn(rstn),
      .level(pin_in),
      .rise(rise),
      .fall(fall)
   );

   always_comb begin
      func = decode_func(func_sel);
      // buffer mode kills both compare output and capture
      match = (func == TCD_COMPARE) && !reg_d_buffer_mode
         && (chan3_counter == chan3_general_reg_d);
      capture = 1'b0;
      if (func == TCD_CAPTURE && !reg_d_buffer_mode) begin
         if (func_sel[3:2] == IC_CASCADE) begin
            capture = chan4_count_tick
               && (chan4_prescale_sel != PSC_UNDIVIDED);
         end else if (func_sel[FSEL_BOTH]) begin
            capture = rise | fall;
         end else if (func_sel[FSEL_FALL]) begin
            capture = fall;
         end else begin
            capture = rise;
         end
      end
   end

   always_comb begin
      next_func_sel = func_sel;
      next_reg_d = chan3_general_reg_d;
      next_buffer_mode = reg_d_buffer_mode;
      next_prescale = chan4_prescale_sel;
      next_enable = enable;
      next_capture_val = capture_val;
      next_pin_level = pin_level;
      next_pin_drive = (decode_func(func_sel) == TCD_COMPARE);
      // initial level loaded when a compare code is newly written
      if (func_sel != prev_func && decode_func(func_sel) == TCD_COMPARE) begin
         next_pin_level = func_sel[FSEL_INIT];
      end
      if (match) begin
         case (func_sel[1:0])
            OC_LOW: next_pin_level = 1'b0;
            OC_HIGH: next_pin_level = 1'b1;
            OC_TOGGLE: next_pin_level = ~pin_level;
            default: next_pin_level = pin_level;
         endcase
      end
      if (capture) begin
         next_capture_val = chan3_counter;
      end
      next_status = status;
      if (wr) begin
         if (addr == ADDR_FUNC) begin
            next_func_sel = wdata[3:0];
         end else if (addr == ADDR_COMPARE) begin
            next_reg_d = wdata;
         end else if (addr == ADDR_CLEAR) begin
            next_status = status & ~wdata[ST_W-1:0];
         end else if (addr == ADDR_ENABLE) begin
            next_enable = wdata[ST_W-1:0];
         end else if (addr == ADDR_MODE) begin
            next_buffer_mode = wdata[MODE_BUF];
            next_prescale = wdata[MODE_PSC +: MODE_PSC_W];
         end
      end
      // set wins over a clear in the same cycle
      if (match) begin
         next_status[ST_MATCH] = 1'b1;
      end
      if (capture) begin
         next_status[ST_CAPT] = 1'b1;
      end
      next_irq = |(next_status & next_enable);
      next_rdata = rdata;
      if (rd) begin
         if (addr == ADDR_FUNC) begin
            next_rdata = {12'h000, func_sel};
         end else if (addr == ADDR_COMPARE) begin
            next_rdata = chan3_general_reg_d;
         end else if (addr == ADDR_CAPTURE) begin
            next_rdata = capture_val;
         end else if (addr == ADDR_STATUS) begin
            next_rdata = {14'h0000, status};
         end else if (addr == ADDR_ENABLE) begin
            next_rdata = {14'h0000, enable};
         end else if (addr == ADDR_MODE) begin
            next_rdata = {12'h000, chan4_prescale_sel, reg_d_buffer_mode};
         end else begin
            next_rdata = CNT_RESET;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         func_sel <= FSEL_RESET;
         prev_func <= FSEL_RESET;
         chan3_general_reg_d <= CNT_RESET;
         capture_val <= CNT_RESET;
         reg_d_buffer_mode <= 1'b0;
         chan4_prescale_sel <= PSC_UNDIVIDED;
         status <= '0;
         enable <= '0;
         pin_level <= 1'b0;
         pin_drive <= 1'b0;
         irq <= 1'b0;
         rdata <= CNT_RESET;
      end else begin
         func_sel <= next_func_sel;
         prev_func <= func_sel;
         chan3_general_reg_d <= next_reg_d;
         capture_val <= next_capture_val;
         reg_d_buffer_mode <= next_buffer_mode;
         chan4_prescale_sel <= next_prescale;
         status <= next_status;
         enable <= next_enable;
         pin_level <= next_pin_level;
         pin_drive <= next_pin_drive;
         irq <= next_irq;
         rdata <= next_rdata;
      end
   end

   assign pin_out = pin_level;
   assign pin_oe = pin_drive;

   // compare output
   // a match in the cycle after a code write overrides the initial level, acting on the old level
   a_match_low: assert property (@(posedge clk) disable iff (!rstn)
      match && func_sel[1:0] == OC_LOW && func_sel == prev_func |=> !pin_out)
      else $error("pin not low after match");
   a_match_high: assert property (@(posedge clk) disable iff (!rstn)
      match && func_sel[1:0] == OC_HIGH && func_sel == prev_func |=> pin_out)
      else $error("pin not high after match");
   a_match_toggle: assert property (@(posedge clk) disable iff (!rstn)
      match && func_sel[1:0] == OC_TOGGLE && func_sel == prev_func
      |=> pin_out != $past(pin_out))
      else $error("pin not toggled");
   a_pin_hold: assert property (@(posedge clk) disable iff (!rstn)
      !match && func_sel == prev_func |=> $stable(pin_out))
      else $error("pin moved without match");
   a_init_level: assert property (@(posedge clk) disable iff (!rstn)
      func_sel != prev_func && !func_sel[FSEL_TOP] && func_sel[1:0] != OC_OFF && !match
      |=> pin_out == $past(func_sel[FSEL_INIT]))
      else $error("initial level not loaded");
   a_oc_drive: assert property (@(posedge clk) disable iff (!rstn)
      !func_sel[FSEL_TOP] && func_sel[1:0] != OC_OFF |=> pin_oe)
      else $error("output not enabled in compare");
   a_off_hiz: assert property (@(posedge clk) disable iff (!rstn)
      func_sel[FSEL_TOP] || func_sel[1:0] == OC_OFF |=> !pin_oe)
      else $error("output enabled when off");

   // input capture
   a_rise_capt: assert property (@(posedge clk) disable iff (!rstn)
      func_sel == 4'h8 && !reg_d_buffer_mode && rise
      |=> capture_val == $past(chan3_counter))
      else $error("rising capture missed");
   a_rise_only: assert property (@(posedge clk) disable iff (!rstn)
      func_sel == 4'h8 && !rise |-> !capture)
      else $error("capture without rising edge");
   a_fall_capt: assert property (@(posedge clk) disable iff (!rstn)
      func_sel == 4'h9 && !reg_d_buffer_mode && fall |=> status[ST_CAPT])
      else $error("falling capture missed");
   a_fall_only: assert property (@(posedge clk) disable iff (!rstn)
      func_sel == 4'h9 && !fall |-> !capture)
      else $error("capture without falling edge");
   a_both_capt: assert property (@(posedge clk) disable iff (!rstn)
      func_sel[3:1] == 3'h5 && !reg_d_buffer_mode && (rise || fall)
      |=> capture_val == $past(chan3_counter))
      else $error("edge capture missed");
   a_both_only: assert property (@(posedge clk) disable iff (!rstn)
      func_sel[3:1] == 3'h5 && !rise && !fall |-> !capture)
      else $error("capture without pin edge");
   a_casc_capt: assert property (@(posedge clk) disable iff (!rstn)
      func_sel[3:2] == IC_CASCADE && !reg_d_buffer_mode
      && chan4_prescale_sel != PSC_UNDIVIDED && chan4_count_tick
      |=> status[ST_CAPT] && capture_val == $past(chan3_counter))
      else $error("cascade capture missed");
   a_casc_pin: assert property (@(posedge clk) disable iff (!rstn)
      func_sel[3:2] == IC_CASCADE && !chan4_count_tick |-> !capture)
      else $error("cascade capture without tick");
   a_capt_hold: assert property (@(posedge clk) disable iff (!rstn)
      !capture |=> $stable(capture_val))
      else $error("capture value moved");
   a_psc_block: assert property (@(posedge clk) disable iff (!rstn)
      func_sel[3:2] == IC_CASCADE && chan4_prescale_sel == PSC_UNDIVIDED |-> !capture)
      else $error("capture with undivided clock");
   a_psc_hold: assert property (@(posedge clk) disable iff (!rstn)
      func_sel[3:2] == IC_CASCADE && chan4_prescale_sel == PSC_UNDIVIDED
      |=> $stable(capture_val))
      else $error("capture value moved with undivided clock");
   a_buf_block: assert property (@(posedge clk) disable iff (!rstn)
      reg_d_buffer_mode |-> !capture && !match)
      else $error("event in buffer mode");
   a_buf_capt: assert property (@(posedge clk) disable iff (!rstn)
      reg_d_buffer_mode |=> $stable(capture_val))
      else $error("capture value moved in buffer mode");
   a_buf_pin: assert property (@(posedge clk) disable iff (!rstn)
      reg_d_buffer_mode && func_sel == prev_func |=> $stable(pin_out))
      else $error("pin moved in buffer mode");

   // status flags and interrupt
   // a clear in the cycle of a new event loses, so no event goes unseen
   a_set_wins: assert property (@(posedge clk) disable iff (!rstn)
      match && wr && addr == ADDR_CLEAR && wdata[ST_MATCH] |=> status[ST_MATCH])
      else $error("clear beat a new match");
   a_capt_flag: assert property (@(posedge clk) disable iff (!rstn)
      capture |=> status[ST_CAPT])
      else $error("capture flag not set");
   a_flag_clear: assert property (@(posedge clk) disable iff (!rstn)
      wr && addr == ADDR_CLEAR && wdata[ST_CAPT] && !capture |=> !status[ST_CAPT])
      else $error("capture flag not cleared");
   a_match_clear: assert property (@(posedge clk) disable iff (!rstn)
      wr && addr == ADDR_CLEAR && wdata[ST_MATCH] && !match |=> !status[ST_MATCH])
      else $error("match flag not cleared");
   a_flag_sticky: assert property (@(posedge clk) disable iff (!rstn)
      status[ST_MATCH] && !(wr && addr == ADDR_CLEAR) |=> status[ST_MATCH])
      else $error("match flag lost");
   a_capt_sticky: assert property (@(posedge clk) disable iff (!rstn)
      status[ST_CAPT] && !(wr && addr == ADDR_CLEAR) |=> status[ST_CAPT])
      else $error("capture flag lost");
   a_irq_level: assert property (@(posedge clk) disable iff (!rstn)
      irq == |(status & enable))
      else $error("interrupt level wrong");

   // register port
   a_write_func: assert property (@(posedge clk) disable iff (!rstn)
      wr && addr == ADDR_FUNC |=> func_sel == $past(wdata[3:0]))
      else $error("function write lost");
   a_write_cmp: assert property (@(posedge clk) disable iff (!rstn)
      wr && addr == ADDR_COMPARE |=> chan3_general_reg_d == $past(wdata))
      else $error("compare write lost");
   a_write_enable: assert property (@(posedge clk) disable iff (!rstn)
      wr && addr == ADDR_ENABLE |=> enable == $past(wdata[ST_W-1:0]))
      else $error("enable write lost");
   a_write_mode: assert property (@(posedge clk) disable iff (!rstn)
      wr && addr == ADDR_MODE |=> reg_d_buffer_mode == $past(wdata[MODE_BUF])
      && chan4_prescale_sel == $past(wdata[MODE_PSC +: MODE_PSC_W]))
      else $error("mode write lost");
   a_read_func: assert property (@(posedge clk) disable iff (!rstn)
      rd && addr == ADDR_FUNC |=> rdata == {12'h000, $past(func_sel)})
      else $error("function read wrong");
   a_read_cmp: assert property (@(posedge clk) disable iff (!rstn)
      rd && addr == ADDR_COMPARE |=> rdata == $past(chan3_general_reg_d))
      else $error("compare read wrong");
   a_read_status: assert property (@(posedge clk) disable iff (!rstn)
      rd && addr == ADDR_STATUS |=> rdata == {14'h0000, $past(status)})
      else $error("status read wrong");
   a_read_capt: assert property (@(posedge clk) disable iff (!rstn)
      rd && addr == ADDR_CAPTURE |=> rdata == $past(capture_val))
      else $error("capture read wrong");
   a_read_mode: assert property (@(posedge clk) disable iff (!rstn)
      rd && addr == ADDR_MODE
      |=> rdata == {12'h000, $past(chan4_prescale_sel), $past(reg_d_buffer_mode)})
      else $error("mode read wrong");
   a_read_gap: assert property (@(posedge clk) disable iff (!rstn)
      rd && addr > ADDR_MODE |=> rdata == CNT_RESET)
      else $error("unmapped read not zero");
   a_rdata_hold: assert property (@(posedge clk) disable iff (!rstn)
      !rd |=> $stable(rdata))
      else $error("read data moved without read");

   // main scenarios
   c_toggle: cover property (@(posedge clk) disable iff (!rstn)
      match && func_sel[1:0] == OC_TOGGLE);
   c_both: cover property (@(posedge clk) disable iff (!rstn)
      capture && func_sel[3:1] == 3'h5);
   c_casc: cover property (@(posedge clk) disable iff (!rstn)
      capture && func_sel[3:2] == IC_CASCADE);
   c_irq: cover property (@(posedge clk) disable iff (!rstn) $rose(irq));
   c_set_wins: cover property (@(posedge clk) disable iff (!rstn)
      match && wr && addr == ADDR_CLEAR);
endmodule // tcd_ctrl

//--- design/tcd_edge_det.sv
`timescale 1ns/1ps
module tcd_edge_det (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // sampled level and edges
   input wire logic level,
   output logic rise,
   output logic fall
);
   logic prev;
   logic armed;
   logic next_prev;
   logic next_armed;

   always_comb begin
      next_prev = level;
      next_armed = 1'b1;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         prev <= 1'b0;
         armed <= 1'b0;
      end else begin
         prev <= next_prev;
         armed <= next_armed;
      end
   end

   // no edge in the first cycle after reset, whatever level the pin idles at
   assign rise = armed & level & ~prev;
   assign fall = armed & ~level & prev;
endmodule // tcd_edge_det

//--- verif/tb_tcd_ctrl.sv
`timescale 1ns/1ps
module tb_tcd_ctrl;
   import tcd_pkg::*;
   logic clk = 0, rstn = 0, wr = 0, rd = 0, ld = 0, run = 0, pin_lvl = 0, tick_req = 0;
   logic [3:0] addr = 4'h0;
   logic [15:0] wdata = 16'h0000, ld_val = 16'h0000, rdata, cnt3;
   logic pin_in, tick, pin_out, pin_oe, irq;
   int err_total = 0, total_checks = 0;
   always #12.5 clk = ~clk;
   tcd_far_model u_tcd_far_model (.clk(clk), .rstn(rstn), .ld(ld), .ld_val(ld_val), .run(run),
      .pin_lvl(pin_lvl), .tick_req(tick_req), .chan3_counter(cnt3), .pin_in(pin_in),
      .chan4_count_tick(tick));
   tcd_ctrl u_tcd_ctrl (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .chan3_counter(cnt3), .chan4_count_tick(tick), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq));
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out;
      if (err_total == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      chk(rdata, exp);
   endtask
   task automatic ld_cnt(input logic [15:0] v);
      @(posedge clk);
      ld <= 1'b1;
      ld_val <= v;
      @(posedge clk);
      ld <= 1'b0;
   endtask
   task automatic comp_case(input logic [3:0] code);
      logic [1:0] low;
      logic exp;
      low = code[1:0];
      exp = (low == OC_LOW) ? 1'b0 : (low == OC_HIGH) ? 1'b1 : ~code[2];
      wr_reg(ADDR_FUNC, {12'h000, code});
      cyc(3);
      chk(16'(pin_oe), 16'(low != OC_OFF));
      if (low != OC_OFF) chk(16'(pin_out), 16'(code[2]));
      run <= 1'b1;
      ld_cnt(16'h00FC);
      cyc(8);
      run <= 1'b0;
      if (low != OC_OFF) begin
         chk(16'(pin_out), 16'(exp));
         rd_chk(ADDR_STATUS, 16'h0001);
         chk(16'(irq), 16'h0001);
      end
      wr_reg(ADDR_CLEAR, 16'h0003);
      cyc(2);
      chk(16'(irq), 16'h0000);
   endtask
   // kind: 0 rising pin, 1 falling pin, 2 neighbour count tick
   task automatic cap_case(input logic [3:0] code, input logic [15:0] mode, input int kind,
         input logic hit);
      logic [15:0] v;
      v = {8'h5A, kind[3:0], code};
      wr_reg(ADDR_MODE, mode);
      wr_reg(ADDR_FUNC, {12'h000, code});
      @(posedge clk);
      pin_lvl <= (kind == 1);
      cyc(3);
      ld_cnt(v);
      wr_reg(ADDR_CLEAR, 16'h0003);
      @(posedge clk);
      if (kind == 2) tick_req <= 1'b1;
      else pin_lvl <= ~pin_lvl;
      @(posedge clk);
      tick_req <= 1'b0;
      cyc(2);
      rd_chk(ADDR_STATUS, {14'h0000, hit, 1'b0});
      if (hit) rd_chk(ADDR_CAPTURE, v);
      chk(16'(irq), 16'(hit));
   endtask
   initial begin
      #500000;
      err_total++;
      close_out();
   end
   initial begin
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      rd_chk(ADDR_FUNC, 16'h0000);
      chk({14'h0000, pin_oe, irq}, 16'h0000);
      rd_chk(4'hF, 16'h0000);
      wr_reg(ADDR_MODE, 16'h0002);
      wr_reg(ADDR_ENABLE, 16'h0003);
      wr_reg(ADDR_COMPARE, 16'h0100);
      for (int c = 0; c < 8; c++) comp_case(c[3:0]);
      wr_reg(ADDR_MODE, 16'h0003);
      wr_reg(ADDR_FUNC, 16'h0003);
      run <= 1'b1;
      ld_cnt(16'h00FC);
      cyc(8);
      run <= 1'b0;
      rd_chk(ADDR_STATUS, 16'h0000);
      chk(16'(pin_out), 16'h0000);
      cap_case(4'h8, 16'h0002, 0, 1'b1);
      cap_case(4'h8, 16'h0002, 1, 1'b0);
      cap_case(4'h9, 16'h0002, 1, 1'b1);
      cap_case(4'h9, 16'h0002, 0, 1'b0);
      cap_case(4'hA, 16'h0002, 0, 1'b1);
      cap_case(4'hB, 16'h0002, 1, 1'b1);
      cap_case(4'hC, 16'h0002, 2, 1'b1);
      cap_case(4'hF, 16'h0002, 0, 1'b0);
      cap_case(4'hE, 16'h0000, 2, 1'b0);
      cap_case(4'h8, 16'h0003, 0, 1'b0);
      close_out();
   end
endmodule // tb_tcd_ctrl

//--- verif/tcd_far_model.sv
`timescale 1ns/1ps
module tcd_far_model (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // bench requests
   input wire logic ld,
   input wire logic [15:0] ld_val,
   input wire logic run,
   input wire logic pin_lvl,
   input wire logic tick_req,
   // toward the block
   output logic [15:0] chan3_counter,
   output logic pin_in,
   output logic chan4_count_tick
);
   // pin is always driven by its source, so no released level exists
   assign pin_in = pin_lvl;
   assign chan4_count_tick = tick_req;
   // loadable so capture values are known without a free-running race
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) chan3_counter <= 16'h0000;
      else if (ld) chan3_counter <= ld_val;
      else if (run) chan3_counter <= chan3_counter + 16'h0001;
   end
endmodule // tcd_far_model
